/* File: rtl/pixel_stream_readout.sv */
// Top level: row sequencing, pixel processing, FIFO and serial output
// Function
// - Scan array progressively, stream pixels continuously at constant frame rate.
// - All internal timing derives from one master clock of 6 to 27 MHz; here clk is taken as 125 MHz (CLK_MHZ).
// - Pixel throughput limited to 64 Mp/s by the pixel enable divider.
// - Step rows one at a time: reset each row, later read it; here row_reset_r pulses in the same cycle as row_read_r.
// - Exposure equals delay between a row's reset and its readout; here reset_row drives nothing and row_reset_r pulses with row_read_r.
// - One 10-bit conversion result per pixel after offset and gain.
// - Each pixel gets further corrections then a digital gain.
// - Dark pixel readings feed the black-level offset correction.
// - Default settings give full frames at fixed rate from 16 MHz clock.
// - Even rows carry green/red, odd rows blue/green.
// - Even columns hold green/blue, odd columns red/green.
// - Output path: scaling, limiter, compressor, FIFO, serializer.
// - Output FIFO absorbs bursts so data leaves at continuous rate.
// - Frame size, exposure and gain are set by the controlling party; here frame size is fixed at 1608 x 1208.
// - Serial link mode fixed at manufacture, CCP2 or single-lane MIPI.
// - Reset low stops output and restores all state to defaults.
`timescale 1ns/1ps
module pixel_stream_readout
    import readout_pkg::*;
#(
    parameter bit LINK_MIPI = 1'b0
) (
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire logic                         link_clk,
    input  wire logic [readout_pkg::PIX_W-1:0] adc_data,
    input  wire logic [7:0]                   gain_cfg,
    input  wire logic [readout_pkg::ROW_W-1:0] expo_rows_cfg,
    input  wire logic                         half_scale_cfg,
    output logic                              row_reset_r,
    output logic                              row_read_r,
    output logic [readout_pkg::ROW_W-1:0]      row_addr_r,
    output logic [readout_pkg::COL_W-1:0]      col_addr_r,
    output logic                              frame_start_r,
    output logic                              link_mode_r,
    output logic                              ser_data_o_r,
    output logic                              ser_strobe_o_r,
    output logic                              fifo_stall_r
);
    import readout_pkg::*;

    // ****************************************************
    // Input synchronisers
    // ****************************************************
    logic       lclk_m_r;
    logic       lclk_s_r;
    logic       lclk_d_r;
    logic       bit_tick;

    // Two stages before the link clock edge detector
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lclk_m_r <= 1'b0;
            lclk_s_r <= 1'b0;
            lclk_d_r <= 1'b0;
        end
        else
        begin
            lclk_m_r <= link_clk;
            lclk_s_r <= lclk_m_r;
            lclk_d_r <= lclk_s_r;
        end
    end
    assign bit_tick = lclk_s_r && !lclk_d_r;   // Rising edge of link clock

    // ****************************************************
    // Pixel rate divider
    // ****************************************************
    logic [1:0] div_r;
    logic       pix_en;

    // One-cycle enable caps the pixel rate
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            div_r <= '0;
        else
            div_r <= (div_r == PIX_DIV_LAST) ? '0 : div_r + 1'b1;
    end
    assign pix_en = (div_r == PIX_DIV_LAST);

    // ****************************************************
    // Row and column sequencing
    // ****************************************************
    logic                 advance;
    logic                 hold;
    logic                 fifo_in_ready;
    logic                 col_end;
    logic                 row_end;
    logic [ROW_W-1:0]     expo_r;
    logic [ROW_W:0]       rst_row_sum;

    // Scan halts while a finished word waits for FIFO room, so no pixel is lost
    assign advance = pix_en && !hold;
    assign col_end = (col_addr_r == COL_LAST);
    assign row_end = (row_addr_r == ROW_LAST);

    // Exposure setting captured at frame start so a frame stays consistent
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            expo_r <= EXPO_INIT;
        else if (advance && col_end && row_end)
            expo_r <= (expo_rows_cfg > ROW_LAST) ? ROW_LAST : expo_rows_cfg;
    end

    // Progressive scan: columns within a row, rows in turn
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            col_addr_r    <= '0;
            row_addr_r    <= '0;
            frame_start_r <= 1'b0;
        end
        else
        begin
            frame_start_r <= advance && col_end && row_end;
            if (advance)
            begin
                col_addr_r <= col_end ? '0 : col_addr_r + 1'b1;
                if (col_end)
                    row_addr_r <= row_end ? '0 : row_addr_r + 1'b1;
            end
        end
    end

    // Reset pointer leads the read pointer by the exposure in rows
    assign rst_row_sum = {1'b0, row_addr_r} + {1'b0, expo_r};

    // Row read strobe at the start of each row, with the row reset strobe unless the exposure is zero
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            row_reset_r <= 1'b0;
            row_read_r  <= 1'b0;
        end
        else
        begin
            row_reset_r <= advance && (col_addr_r == '0) && (expo_r != '0);
            row_read_r  <= advance && (col_addr_r == '0);
        end
    end

    logic [ROW_W-1:0] reset_row;
    assign reset_row = (rst_row_sum > {1'b0, ROW_LAST})
                     ? ROW_W'(rst_row_sum - (ROW_W+1)'(ROWS))
                     : rst_row_sum[ROW_W-1:0];

    // ****************************************************
    // Colour tag and dark rows
    // ****************************************************
    logic [1:0] colour;
    logic       dark_row;

    // Row bit picks the line pair, column bit the sample
    always_comb
    begin
        unique case ({row_addr_r[0], col_addr_r[0]})
            2'b00:   colour = COL_GR;
            2'b01:   colour = COL_R;
            2'b10:   colour = COL_B;
            2'b11:   colour = COL_GB;
        endcase
    end
    assign dark_row = (row_addr_r <= DARK_LAST);

    // ****************************************************
    // Stage 1: capture conversion result
    // ****************************************************
    logic [PIX_W-1:0] s1_pix_r;
    logic [1:0]       s1_col_r;
    logic             s1_dark_r;
    logic             s1_valid_r;

    // One 10-bit sample per pixel position
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_pix_r   <= '0;
            s1_col_r   <= '0;
            s1_dark_r  <= 1'b0;
            s1_valid_r <= 1'b0;
        end
        else if (!hold)
        begin
            s1_valid_r <= advance;
            if (advance)
            begin
                s1_pix_r  <= adc_data;
                s1_col_r  <= colour;
                s1_dark_r <= dark_row;
            end
        end
    end

    // ****************************************************
    // Black level from dark rows
    // ****************************************************
    logic [PIX_W-1:0] black_r;
    logic [PIX_W:0]   black_avg;

    // Running average of dark samples; each new sample moves the level halfway toward it
    assign black_avg = ({1'b0, black_r} + {1'b0, s1_pix_r}) >> 1;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            black_r <= BLACK_INIT;
        else if (s1_valid_r && s1_dark_r && !hold)
            black_r <= black_avg[PIX_W-1:0];
    end

    // ****************************************************
    // Stage 2: correction and digital gain
    // ****************************************************
    logic [PIX_W-1:0] corr;
    logic [17:0]      gained;
    logic [PIX_W-1:0] s2_pix_r;
    logic [1:0]       s2_col_r;
    logic             s2_valid_r;
    logic             keep;
    logic             row_odd_r;
    logic             col_odd_r;

    // Subtract black, then gain in 4.4 fixed point
    assign corr   = (s1_pix_r > black_r) ? s1_pix_r - black_r : '0;
    assign gained = (18'(corr) * 18'(gain_cfg)) >> 4;

    // Limiter clips the gained value to full scale
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s2_pix_r   <= '0;
            s2_col_r   <= '0;
            s2_valid_r <= 1'b0;
        end
        else if (!hold)
        begin
            s2_valid_r <= s1_valid_r && !s1_dark_r && keep;
            s2_col_r   <= s1_col_r;
            s2_pix_r   <= (gained > 18'(PIX_MAXV)) ? PIX_MAXV : gained[PIX_W-1:0];
        end
    end

    // ****************************************************
    // Stage 3: scaler and compressor
    // ****************************************************
    logic [PIX_W-1:0] cmp;
    logic [WORD_W-1:0] word_r;
    logic             word_valid_r;

    // A word that the full FIFO cannot take freezes the whole pipeline
    assign hold = word_valid_r && !fifo_in_ready;

    // Half-scale keeps one Bayer quad in four, preserving the colour order
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            row_odd_r <= 1'b0;
            col_odd_r <= 1'b0;
        end
        else if (advance)
        begin
            row_odd_r <= row_addr_r[1];   // Taken with stage 1 so it follows the pixel
            col_odd_r <= col_addr_r[1];
        end
    end
    assign keep = !half_scale_cfg || (!row_odd_r && !col_odd_r);

    // Compressor: single knee at mid scale, slope halved above it
    assign cmp = s2_pix_r[9] ? {2'b10, s2_pix_r[8:1]}
                             : s2_pix_r;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            word_r       <= '0;
            word_valid_r <= 1'b0;
        end
        else if (!hold)
        begin
            word_valid_r <= s2_valid_r;
            word_r       <= {s2_col_r, cmp};
        end
    end

    // ****************************************************
    // Output FIFO and serializer
    // ****************************************************
    logic [WORD_W-1:0] fifo_data;
    logic              fifo_valid;
    logic              ser_ready;
    logic              ser_data;
    logic              ser_strobe;

    // Smooths the processing bursts into the steady link rate
    stream_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_data   (word_r),
        .in_valid  (word_valid_r),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (ser_ready)
    );

    link_serializer #(
        .WIDTH (WORD_W)
    ) u_ser (
        .clk          (clk),
        .resetn       (resetn),
        .bit_tick     (bit_tick),
        .word         (fifo_data),
        .word_valid   (fifo_valid),
        .word_ready   (ser_ready),
        .ser_data_r   (ser_data),
        .ser_strobe_r (ser_strobe)
    );

    // Registered outputs; reset holds the link silent
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ser_data_o_r   <= 1'b0;
            ser_strobe_o_r <= 1'b0;
            fifo_stall_r   <= 1'b0;
            link_mode_r    <= 1'b0;
        end
        else
        begin
            ser_data_o_r   <= ser_data;
            ser_strobe_o_r <= ser_strobe;
            fifo_stall_r   <= pix_en && hold;
            link_mode_r    <= LINK_MIPI;
        end
    end

    // Unused shadow of the reset pointer, folded into one bit that drives nothing
    logic unused_reset_row;
    assign unused_reset_row = ^reset_row;
endmodule : pixel_stream_readout

/* File: rtl/readout_pkg.sv */
// Package: constants for the pixel stream readout block
package readout_pkg;
    // ****************************************************
    // Array geometry and pixel format
    // ****************************************************
    localparam int          PIX_W        = 10;
    localparam int          COLS         = 1608;
    localparam int          ROWS         = 1208;
    localparam int          COL_W        = 11;
    localparam int          ROW_W        = 11;
    localparam int          DARK_ROWS    = 4;
    localparam logic [COL_W-1:0] COL_LAST = 11'h647;
    localparam logic [ROW_W-1:0] ROW_LAST = 11'h4B7;
    localparam logic [ROW_W-1:0] DARK_LAST = 11'h003;
    // ****************************************************
    // Colour tags
    // ****************************************************
    localparam logic [1:0]  COL_GR       = 2'h0;
    localparam logic [1:0]  COL_R        = 2'h1;
    localparam logic [1:0]  COL_B        = 2'h2;
    localparam logic [1:0]  COL_GB       = 2'h3;
    // ****************************************************
    // Clocking
    // ****************************************************
    localparam int          CLK_MHZ      = 125;
    localparam int          EXT_MIN_MHZ  = 6;
    localparam int          EXT_MAX_MHZ  = 27;
    localparam int          PIX_MAX_MPS  = 64;
    // Pixel enable divider: at most 64 Mp/s, so round up to 2 cycles
    localparam int          PIX_DIV      = (CLK_MHZ + PIX_MAX_MPS - 1) / PIX_MAX_MPS;
    localparam logic [1:0]  PIX_DIV_LAST = 2'(PIX_DIV - 1);
    // ****************************************************
    // Processing defaults
    // ****************************************************
    localparam logic [7:0]  GAIN_UNITY   = 8'h10;
    localparam logic [9:0]  BLACK_INIT   = 10'h040;
    localparam logic [9:0]  PIX_MAXV     = 10'h3FF;
    localparam logic [ROW_W-1:0] EXPO_INIT = 11'h010;
    localparam int          FIFO_DEPTH   = 4;
    localparam int          WORD_W       = 12;
endpackage : readout_pkg

/* File: rtl/stream_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr_r;
    logic [AW-1:0]    rptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // Handshakes; full and empty come straight from the count
    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rptr_r];

    // Storage, no reset needed on data
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wptr_r] <= in_data;
    end

    // Pointers and count
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wptr_r  <= '0;
            rptr_r  <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
                wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
            if (pop)
                rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : stream_fifo

/* File: rtl/link_serializer.sv */
// Serializer that shifts FIFO words out on the sampled link clock
`timescale 1ns/1ps
module link_serializer #(
    parameter int WIDTH = 12
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             bit_tick,
    input  wire logic [WIDTH-1:0] word,
    input  wire logic             word_valid,
    output logic                  word_ready,
    output logic                  ser_data_r,
    output logic                  ser_strobe_r
);
    logic [WIDTH-1:0] shift_r;
    logic [4:0]       left_r;

    // Take a new word only when the previous one has fully left
    assign word_ready = (left_r == '0) && bit_tick;

    // One bit per rising link clock edge, MSB first; strobe marks first bit of a word
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            shift_r      <= '0;
            left_r       <= '0;
            ser_data_r   <= 1'b0;
            ser_strobe_r <= 1'b0;
        end
        else if (bit_tick)
        begin
            if (left_r == '0)
            begin
                ser_strobe_r <= word_valid;
                ser_data_r   <= word_valid ? word[WIDTH-1] : 1'b0;
                shift_r      <= {word[WIDTH-2:0], 1'b0};
                left_r       <= word_valid ? 5'(WIDTH-1) : '0;
            end
            else
            begin
                ser_strobe_r <= 1'b0;
                ser_data_r   <= shift_r[WIDTH-1];
                shift_r      <= {shift_r[WIDTH-2:0], 1'b0};
                left_r       <= left_r - 1'b1;
            end
        end
    end
endmodule : link_serializer

/* File: testbench/readout_chk.sv */
// Checker: port-level assertions for the pixel stream readout
`timescale 1ns/1ps
module readout_chk #(
    parameter bit LINK_MIPI = 1'b0
) (
    input wire logic                           clk,
    input wire logic                           resetn,
    input wire logic                           link_clk,
    input wire logic [readout_pkg::PIX_W-1:0]  adc_data,
    input wire logic [7:0]                     gain_cfg,
    input wire logic [readout_pkg::ROW_W-1:0]  expo_rows_cfg,
    input wire logic                           half_scale_cfg,
    input wire logic                           row_reset_r,
    input wire logic                           row_read_r,
    input wire logic [readout_pkg::ROW_W-1:0]  row_addr_r,
    input wire logic [readout_pkg::COL_W-1:0]  col_addr_r,
    input wire logic                           frame_start_r,
    input wire logic                           link_mode_r,
    input wire logic                           ser_data_o_r,
    input wire logic                           ser_strobe_o_r,
    input wire logic                           fifo_stall_r
);
    import readout_pkg::*;
    // ****************************************
    // Helper logic and sequences
    // ****************************************
    logic [7:0] gap_r;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Clocks since a word began; saturates so long idle never wraps
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            gap_r <= 8'hFF;
        else if ($rose(ser_strobe_o_r))
            gap_r <= 8'h00;
        else if (gap_r != 8'hFF)
            gap_r <= gap_r + 8'h01;
    // One link slot of about eight clocks, then the strobe drops
    sequence msb_slot;
        ser_strobe_o_r [*6] ##[1:4] !ser_strobe_o_r;
    endsequence
    // ****************************************
    // Assertions
    // ****************************************
    a_read_pulse: assert property (row_read_r |=> !row_read_r)
        else $error("row read pulse longer than one cycle");
    a_reset_with_read: assert property (row_reset_r |-> row_read_r)
        else $error("row reset outside a row start");
    a_read_col_zero: assert property (row_read_r |-> $past(col_addr_r) == 11'h000)
        else $error("row read away from column zero");
    a_col_step: assert property (($changed(col_addr_r) && $past(col_addr_r) != COL_LAST)
        |-> col_addr_r == $past(col_addr_r) + 11'h001)
        else $error("column address skipped");
    a_row_on_wrap: assert property ($changed(row_addr_r)
        |-> col_addr_r == 11'h000 && $past(col_addr_r) == COL_LAST)
        else $error("row changed before last column");
    a_addr_range: assert property (row_addr_r <= ROW_LAST && col_addr_r <= COL_LAST)
        else $error("scan address out of array");
    a_pixel_rate: assert property ($changed(col_addr_r) |=> $stable(col_addr_r))
        else $error("pixel rate above limit");
    a_link_mode: assert property ($past(resetn) |-> link_mode_r == LINK_MIPI)
        else $error("link mode differs from build setting");
    a_msb_slot: assert property ($rose(ser_strobe_o_r) |-> msb_slot)
        else $error("word strobe not one slot long");
    a_word_gap: assert property ($rose(ser_strobe_o_r) |-> gap_r >= 8'h5A)
        else $error("words closer than twelve slots");
endmodule : readout_chk

bind pixel_stream_readout readout_chk #(.LINK_MIPI(LINK_MIPI)) u_chk (
    .clk(clk), .resetn(resetn), .link_clk(link_clk), .adc_data(adc_data),
    .gain_cfg(gain_cfg), .expo_rows_cfg(expo_rows_cfg), .half_scale_cfg(half_scale_cfg),
    .row_reset_r(row_reset_r), .row_read_r(row_read_r), .row_addr_r(row_addr_r),
    .col_addr_r(col_addr_r), .frame_start_r(frame_start_r), .link_mode_r(link_mode_r),
    .ser_data_o_r(ser_data_o_r), .ser_strobe_o_r(ser_strobe_o_r),
    .fifo_stall_r(fifo_stall_r));

/* File: testbench/link_receiver_model.sv */
// Receiver model: makes the link clock and collects serial words
`timescale 1ns/1ps
module link_receiver_model (
    input  wire logic        run,
    input  wire logic        ser_data,
    input  wire logic        ser_strobe,
    output logic             link_clk,
    output logic      [11:0] rx_word,
    output logic             rx_done
);
    // ****************************************
    // Clock and deserializer
    // ****************************************
    logic [11:0] shift_r;
    int          nbits;
    // Clock runs only while enabled and holds its level otherwise
    initial
    begin
        link_clk = 1'b0;
        #3;
        forever
        begin
            wait (run);
            #32 link_clk = ~link_clk;
        end
    end
    // Sampling one slot late leaves a wide margin around the sender's update
    initial
    begin
        rx_word = 12'h000;
        rx_done = 1'b0;
        shift_r = 12'h000;
        nbits = 0;
    end
    always @(posedge link_clk)
    begin
        rx_done <= 1'b0;
        if (ser_strobe)
        begin
            shift_r = {11'h000, ser_data};
            nbits = 1;
        end
        else if (nbits > 0)
        begin
            shift_r = {shift_r[10:0], ser_data};
            nbits++;
        end
        if (nbits == 12)
        begin
            rx_word = shift_r;
            rx_done <= 1'b1;
            nbits = 0;
        end
    end
endmodule : link_receiver_model

/* File: testbench/tb_top.sv */
// Testbench: dark rows, stall, streaming and reset of the readout
`timescale 1ns/1ps
module tb_top;
    import readout_pkg::*;
    // ****************************************
    // Signals, design and partner
    // ****************************************
    logic             clk, resetn, link_clk, link_run, rx_done;
    logic [PIX_W-1:0] adc_data;
    logic [ROW_W-1:0] row_addr_r;
    logic [COL_W-1:0] col_addr_r;
    logic             row_reset_r, row_read_r, frame_start_r, link_mode_r;
    logic             ser_data_o_r, ser_strobe_o_r, fifo_stall_r;
    logic [11:0]      rx_word;
    logic [11:0]      rxq[$];
    int               num_errors, tests_run, n_reads, n_stalls, n_resets;

    pixel_stream_readout #(.LINK_MIPI(1'b1)) u_dut (
        .clk(clk), .resetn(resetn), .link_clk(link_clk), .adc_data(adc_data),
        .gain_cfg(GAIN_UNITY), .expo_rows_cfg(EXPO_INIT), .half_scale_cfg(1'b0),
        .row_reset_r(row_reset_r), .row_read_r(row_read_r), .row_addr_r(row_addr_r),
        .col_addr_r(col_addr_r), .frame_start_r(frame_start_r), .link_mode_r(link_mode_r),
        .ser_data_o_r(ser_data_o_r), .ser_strobe_o_r(ser_strobe_o_r),
        .fifo_stall_r(fifo_stall_r));
    link_receiver_model u_rx (
        .run(link_run), .ser_data(ser_data_o_r), .ser_strobe(ser_strobe_o_r),
        .link_clk(link_clk), .rx_word(rx_word), .rx_done(rx_done));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Dark rows read zero, away from the start-up black, so correction shows
    always @(negedge clk)
        adc_data <= (row_addr_r <= DARK_LAST) ? 10'h000 : PIX_MAXV;
    // Pulse counters and word collection
    always @(posedge clk)
    begin
        if (row_read_r === 1'b1) n_reads++;
        if (row_reset_r === 1'b1) n_resets++;
        if (fifo_stall_r === 1'b1) n_stalls++;
    end
    always @(posedge rx_done)
        rxq.push_back(rx_word);
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check_eq(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_eq
    task tally_and_finish;
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task check_quiet;
        check_eq(24'({row_reset_r, row_read_r, frame_start_r, ser_data_o_r}), 24'h0);
        check_eq(24'({link_mode_r, ser_strobe_o_r, fifo_stall_r}), 24'h0);
        check_eq(24'({row_addr_r, col_addr_r}), 24'h0);
    endtask : check_quiet
    // ****************************************
    // Scenarios
    // ****************************************
    // Dark rows pass without output, so no back-pressure may appear there
    task test_dark_rows;
        for (int i = 0; i < 20000 && row_addr_r !== 11'h004; i++) @(negedge clk);
        check_eq(24'(row_addr_r), 24'h4);
        check_eq(24'(n_reads >= 4 && n_reads <= 5), 24'h1);
        check_eq(24'(n_resets), 24'h4);
        check_eq(24'(n_stalls), 24'h0);
    endtask : test_dark_rows
    // Link held still: the FIFO fills and the scan must freeze, not drop
    task test_stall;
        logic [COL_W-1:0] col;
        for (int i = 0; i < 200 && fifo_stall_r !== 1'b1; i++) @(negedge clk);
        check_eq(24'(fifo_stall_r), 24'h1);
        col = col_addr_r;
        repeat (40) @(negedge clk);
        check_eq(24'(col_addr_r), 24'(col));
    endtask : test_stall
    // Link runs: Bayer order; full scale less zero black, knee gives 0x2FF
    task test_stream;
        link_run = 1'b1;
        for (int i = 0; i < 3000 && rxq.size() < 10; i++) @(negedge clk);
        check_eq(24'(rxq.size() >= 10), 24'h1);
        for (int i = 0; i < 10 && i < rxq.size(); i++)
        begin
            check_eq(24'(rxq[i][11:10]), 24'(i % 2));
            check_eq(24'(rxq[i][9:0]), 24'h2FF);
        end
    endtask : test_stream
    // Reset in mid-stream quiets every output, then mode returns
    task test_mid_reset;
        resetn = 1'b0;
        repeat (20) @(negedge clk);
        check_quiet();
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        check_eq(24'(link_mode_r), 24'h1);
        check_eq(24'(row_addr_r), 24'h0);
    endtask : test_mid_reset
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        resetn = 1'b0;
        link_run = 1'b0;
        adc_data = BLACK_INIT;
        repeat (20) @(negedge clk);
        check_quiet();
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        check_eq(24'(link_mode_r), 24'h1);
        test_dark_rows();
        test_stall();
        test_stream();
        test_mid_reset();
        tally_and_finish();
    end
    // Whole run needs about 15000 clocks; this leaves ample room
    initial
    begin
        repeat (40000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
endmodule : tb_top
